// ===== verilog/cfl_loader.v
// Configuration loader: fills configuration memory from flash, a master, JTAG or mask memory
// Function
// - Load bitstream into configuration memory after power-up
// - Support active, passive and JTAG modes
// - Active mode makes flash clock internally
// - Send wake-up instruction before any read
// - Wait at least 30 us before fast read
// - Fast read from address zero, sequentially
// - Start programming on reset rising edge
// - JTAG mode takes bitstream through test port
// - Mask memory option replaces external flash
`timescale 1ns/1ps
`default_nettype none
`include "cfl_loader_regs.vh"

module cfl_loader #(
   parameter [15:0] CFG_BYTES = `CFL_CFG_BYTES
)(
   input wire CLOCK_I,
   input wire NRST_I,
   input wire CONFIG_RESET_N_I,
   input wire [1:0] MODE_I,
   input wire [1:0] WIDTH_I,
   input wire MASK_MEM_EN_I,
   output reg SPI_SCK_O,
   output reg SPI_CS_N_O,
   output reg [3:0] SPI_DQ_O,
   output reg [3:0] SPI_DQ_OE_O,
   input wire [3:0] SPI_DQ_I,
   input wire PSV_SCK_I,
   input wire PSV_CS_N_I,
   input wire [7:0] PSV_DQ_I,
   input wire JTAG_TCK_I,
   input wire JTAG_TDI_I,
   input wire JTAG_CFG_SEL_I,
   output reg [15:0] MASK_ADDR_O,
   input wire [7:0] MASK_DATA_I,
   output reg CFG_WR_O,
   output reg [15:0] CFG_ADDR_O,
   output reg [7:0] CFG_DATA_O,
   output reg BUSY_O,
   output reg DONE_O
);

   // Sequencer states
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_WAKE = 4'h1;
   localparam [3:0] ST_WAIT = 4'h2;
   localparam [3:0] ST_CMD = 4'h3;
   localparam [3:0] ST_READ = 4'h4;
   localparam [3:0] ST_PSV = 4'h5;
   localparam [3:0] ST_JTG = 4'h6;
   localparam [3:0] ST_MASK = 4'h7;
   localparam [3:0] ST_DONE = 4'h8;

   // Least wait in cycles, rounded up
   localparam [31:0] WAKE_WAIT_CYC =
      (`CFL_WAKE_WAIT_NS + `CFL_CLK_PERIOD_NS - 32'h0000_0001) / `CFL_CLK_PERIOD_NS;

   // Instruction codes, so that their first bit can be picked out
   localparam [7:0] OP_WAKE = `CFL_OP_WAKE;
   localparam [7:0] OP_FAST_READ = `CFL_OP_FAST_READ;

   // Shift new bits into a byte, most significant first
   function [7:0] shift_in;
      input [7:0] acc;
      input [7:0] bits;
      input [1:0] wc;
      begin
         case (wc)
            `CFL_WIDTH_X1: shift_in = {acc[6:0], bits[0]};
            `CFL_WIDTH_X2: shift_in = {acc[5:0], bits[1:0]};
            `CFL_WIDTH_X4: shift_in = {acc[3:0], bits[3:0]};
            default: shift_in = bits;
         endcase
      end
   endfunction

   // All pins from outside the clock domain, in one vector
   wire [22:0] async_w = {CONFIG_RESET_N_I, MODE_I, WIDTH_I, MASK_MEM_EN_I, SPI_DQ_I,
      PSV_SCK_I, PSV_CS_N_I, PSV_DQ_I, JTAG_TCK_I, JTAG_TDI_I, JTAG_CFG_SEL_I};
   reg [22:0] sync1_q;
   reg [22:0] sync2_q;

   wire rstn_s = sync2_q[22];
   wire [1:0] mode_s = sync2_q[21:20];
   wire [1:0] width_s = sync2_q[19:18];
   wire mask_s = sync2_q[17];
   wire [3:0] dq_s = sync2_q[16:13];
   wire psck_s = sync2_q[12];
   wire pcs_n_s = sync2_q[11];
   wire [7:0] pdq_s = sync2_q[10:3];
   wire tck_s = sync2_q[2];
   wire tdi_s = sync2_q[1];
   wire jsel_s = sync2_q[0];

   reg rstn_prev_q;
   reg psck_prev_q;
   reg tck_prev_q;
   reg [3:0] state_q;
   reg [1:0] width_q;
   reg [2:0] div_q;
   reg [39:0] tx_q;
   reg [5:0] bits_q;
   reg [31:0] wait_q;
   reg mask_ph_q;
   reg [7:0] acc_q;
   reg [3:0] fill_q;
   reg [15:0] byte_cnt_q;

   // Two-flop synchroniser, then a third stage for edge finding
   always @(posedge CLOCK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         sync1_q <= 23'h00_0000;
         sync2_q <= 23'h00_0000;
         rstn_prev_q <= 1'b0;
         psck_prev_q <= 1'b0;
         tck_prev_q <= 1'b0;
      end
      else
      begin
         sync1_q <= async_w;
         sync2_q <= sync1_q;
         rstn_prev_q <= rstn_s;
         psck_prev_q <= psck_s;
         tck_prev_q <= tck_s;
      end
   end

   wire start_w = rstn_s & ~rstn_prev_q;
   wire sck_tick_w = (div_q == `CFL_SCK_HALF - 3'h1);
   wire room_w = (byte_cnt_q != CFG_BYTES);

   // Sample event, bits and width for the byte gatherer
   reg take_w;
   reg [7:0] take_bits_w;
   reg [1:0] take_wc_w;
   always @*
   begin
      take_w = 1'b0;
      take_bits_w = 8'h00;
      take_wc_w = width_q;
      case (state_q)
         ST_READ:
         begin
            // active mode tops out at x4
            take_w = sck_tick_w & ~SPI_SCK_O;
            take_bits_w = {4'h0, dq_s};
            take_wc_w = (width_q == `CFL_WIDTH_X8) ? `CFL_WIDTH_X4 : width_q;
         end
         ST_PSV:
         begin
            // master clock rising edge while selected
            take_w = psck_s & ~psck_prev_q & ~pcs_n_s;
            take_bits_w = pdq_s;
         end
         ST_JTG:
         begin
            // one bit per test clock rise
            take_w = tck_s & ~tck_prev_q & jsel_s;
            take_bits_w = {7'h00, tdi_s};
            take_wc_w = `CFL_WIDTH_X1;
         end
         ST_MASK:
         begin
            // one byte per read of mask memory
            take_w = mask_ph_q;
            take_bits_w = MASK_DATA_I;
            take_wc_w = `CFL_WIDTH_X8;
         end
         default:
         begin
            take_w = 1'b0;
         end
      endcase
   end

   wire [3:0] nbits_w = 4'h1 << take_wc_w;
   wire [3:0] fill_d = fill_q + nbits_w;
   wire [7:0] acc_d = shift_in(acc_q, take_bits_w, take_wc_w);

   // gather bits into bytes and write configuration memory
   always @(posedge CLOCK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         acc_q <= 8'h00;
         fill_q <= 4'h0;
         byte_cnt_q <= 16'h0000;
         CFG_WR_O <= 1'b0;
         CFG_ADDR_O <= 16'h0000;
         CFG_DATA_O <= 8'h00;
      end
      else
      begin
         CFG_WR_O <= 1'b0;
         if (start_w)
         begin
            acc_q <= 8'h00;
            fill_q <= 4'h0;
            byte_cnt_q <= 16'h0000;
         end
         else if (take_w && room_w)
         begin
            acc_q <= acc_d;
            if (fill_d == 4'h8)
            begin
               fill_q <= 4'h0;
               CFG_WR_O <= 1'b1;
               CFG_ADDR_O <= byte_cnt_q;
               CFG_DATA_O <= acc_d;
               byte_cnt_q <= byte_cnt_q + 16'h0001;
            end
            else
            begin
               fill_q <= fill_d;
            end
         end
      end
   end

   // Main sequencer and flash master
   always @(posedge CLOCK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         state_q <= ST_IDLE;
         width_q <= `CFL_WIDTH_X1;
         div_q <= 3'h0;
         tx_q <= 40'h00_0000_0000;
         bits_q <= 6'h00;
         wait_q <= 32'h0000_0000;
         mask_ph_q <= 1'b0;
         MASK_ADDR_O <= 16'h0000;
         SPI_SCK_O <= 1'b0;
         SPI_CS_N_O <= 1'b1;
         SPI_DQ_O <= 4'h0;
         SPI_DQ_OE_O <= 4'h0;
         BUSY_O <= 1'b0;
         DONE_O <= 1'b0;
      end
      else if (!rstn_s)
      begin
         // Held in configuration reset: release the flash, drop done
         state_q <= ST_IDLE;
         div_q <= 3'h0;
         mask_ph_q <= 1'b0;
         SPI_SCK_O <= 1'b0;
         SPI_CS_N_O <= 1'b1;
         SPI_DQ_OE_O <= 4'h0;
         BUSY_O <= 1'b0;
         DONE_O <= 1'b0;
      end
      else
      begin
         // flash clock divided from the internal clock
         div_q <= sck_tick_w ? 3'h0 : div_q + 3'h1;
         case (state_q)
            ST_IDLE:
            begin
               if (start_w)
               begin
                  width_q <= width_s;
                  BUSY_O <= 1'b1;
                  div_q <= 3'h0;
                  if (mask_s)
                  begin
                     state_q <= ST_MASK;
                     MASK_ADDR_O <= 16'h0000;
                  end
                  else if (mode_s == `CFL_MODE_ACTIVE)
                  begin
                     state_q <= ST_WAKE;
                     tx_q <= {`CFL_OP_WAKE, 32'h0000_0000};
                     bits_q <= `CFL_WAKE_BITS;
                     SPI_CS_N_O <= 1'b0;
                     SPI_DQ_O <= {3'h0, OP_WAKE[7]};
                     SPI_DQ_OE_O <= 4'h1;
                  end
                  else if (mode_s == `CFL_MODE_PASSIVE)
                  begin
                     state_q <= ST_PSV;
                  end
                  else
                  begin
                     state_q <= ST_JTG;
                  end
               end
            end
            ST_WAKE, ST_CMD:
            begin
               if (sck_tick_w)
               begin
                  SPI_SCK_O <= ~SPI_SCK_O;
                  if (SPI_SCK_O)
                  begin
                     // Falling edge: present next bit or end the phase
                     if (bits_q == 6'h01)
                     begin
                        SPI_DQ_OE_O <= 4'h0;
                        if (state_q == ST_WAKE)
                        begin
                           state_q <= ST_WAIT;
                           SPI_CS_N_O <= 1'b1;
                           wait_q <= 32'h0000_0000;
                        end
                        else
                        begin
                           state_q <= ST_READ;
                        end
                     end
                     else
                     begin
                        bits_q <= bits_q - 6'h01;
                        tx_q <= {tx_q[38:0], 1'b0};
                        SPI_DQ_O <= {3'h0, tx_q[38]};
                     end
                  end
               end
            end
            ST_WAIT:
            begin
               // at least 30 us between wake-up and read
               if (wait_q >= WAKE_WAIT_CYC - 32'h0000_0001)
               begin
                  state_q <= ST_CMD;
                  tx_q <= {`CFL_OP_FAST_READ, `CFL_READ_START_ADDR, `CFL_DUMMY_BYTE};
                  bits_q <= `CFL_CMD_BITS;
                  SPI_CS_N_O <= 1'b0;
                  SPI_DQ_O <= {3'h0, OP_FAST_READ[7]};
                  SPI_DQ_OE_O <= 4'h1;
                  div_q <= 3'h0;
               end
               else
               begin
                  wait_q <= wait_q + 32'h0000_0001;
               end
            end
            ST_READ:
            begin
               // flash streams data while the clock runs
               // Finish the high half of the clock before deselecting, no short pulse
               if (!room_w && !SPI_SCK_O)
               begin
                  state_q <= ST_DONE;
                  SPI_CS_N_O <= 1'b1;
                  SPI_SCK_O <= 1'b0;
               end
               else if (sck_tick_w)
               begin
                  SPI_SCK_O <= ~SPI_SCK_O;
               end
            end
            ST_MASK:
            begin
               // Address one cycle, data the next
               if (!room_w)
               begin
                  state_q <= ST_DONE;
               end
               else
               begin
                  mask_ph_q <= ~mask_ph_q;
                  if (mask_ph_q)
                  begin
                     MASK_ADDR_O <= MASK_ADDR_O + 16'h0001;
                  end
               end
            end
            ST_PSV, ST_JTG:
            begin
               if (!room_w)
               begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE:
            begin
               BUSY_O <= 1'b0;
               DONE_O <= 1'b1;
               mask_ph_q <= 1'b0;
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== verilog/cfl_loader_regs.vh
// Constants for the configuration loader: codes, opcodes and timing
`ifndef CFL_LOADER_REGS_VH
`define CFL_LOADER_REGS_VH

// Configuration mode strap codes
`define CFL_MODE_ACTIVE 2'h0
`define CFL_MODE_PASSIVE 2'h1
`define CFL_MODE_JTAG 2'h2

// Data line width codes: x1, x2, x4, x8
`define CFL_WIDTH_X1 2'h0
`define CFL_WIDTH_X2 2'h1
`define CFL_WIDTH_X4 2'h2
`define CFL_WIDTH_X8 2'h3

// Serial flash instructions
`define CFL_OP_WAKE 8'hAB
`define CFL_OP_FAST_READ 8'h0B
`define CFL_READ_START_ADDR 24'h00_0000
`define CFL_DUMMY_BYTE 8'h00

// Bits shifted out for the wake-up and the read command phases
`define CFL_WAKE_BITS 6'h08
`define CFL_CMD_BITS 6'h28

// Clock period and least wait after the wake-up instruction, in ns
`define CFL_CLK_PERIOD_NS 32'h0000_0064
`define CFL_WAKE_WAIT_NS 32'h0000_7530

// Cycles of the system clock per half period of the flash clock
`define CFL_SCK_HALF 3'h4

// Default number of bytes in a bitstream
`define CFL_CFG_BYTES 16'h1000

`endif

// ===== verilog/cfl_placeholder_none.v
// Intentionally empty design unit list: all logic lives in cfl_loader.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== tb/cfl_loader_asserts.sv
// Port checks on the configuration loader
`timescale 1ns/1ps
`default_nettype none
module cfl_loader_asserts #(
   parameter logic [15:0] CFG_BYTES = 16'h1000
)(
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   input wire logic CONFIG_RESET_N_I,
   input wire logic [1:0] MODE_I,
   input wire logic MASK_MEM_EN_I,
   input wire logic SPI_SCK_O,
   input wire logic SPI_CS_N_O,
   input wire logic [3:0] SPI_DQ_OE_O,
   input wire logic CFG_WR_O,
   input wire logic [15:0] CFG_ADDR_O,
   input wire logic BUSY_O,
   input wire logic DONE_O
);
   logic [15:0] gap_q;
   logic [15:0] next_q;
   // Deselect time within a load, and the address the next write must use
   always @(posedge CLOCK_I or negedge NRST_I)
      if (!NRST_I)
      begin
         gap_q <= 16'h0000;
         next_q <= 16'h0000;
      end
      else
      begin
         gap_q <= (SPI_CS_N_O && BUSY_O) ? gap_q + 16'h0001 : 16'h0000;
         next_q <= CFG_WR_O ? CFG_ADDR_O + 16'h0001 : (BUSY_O ? next_q : 16'h0000);
      end
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!NRST_I);
   sequence s_cfg_low;
      !CONFIG_RESET_N_I [*5];
   endsequence
   sequence s_sck_high;
      SPI_SCK_O [*4] ##1 !SPI_SCK_O;
   endsequence
   chk_abort_idle: assert property (
      s_cfg_low |-> !BUSY_O && !DONE_O && SPI_CS_N_O && !SPI_SCK_O)
      else $error("loader not idle while held");
   chk_start_select: assert property (
      $rose(CONFIG_RESET_N_I) && MODE_I == 2'h0 && !MASK_MEM_EN_I |-> ##[2:5] !SPI_CS_N_O)
      else $error("flash not selected after start");
   chk_flash_unused: assert property (
      BUSY_O && (MASK_MEM_EN_I || MODE_I != 2'h0) |-> SPI_CS_N_O)
      else $error("flash selected outside active mode");
   chk_wake_wait: assert property (
      $fell(SPI_CS_N_O) && gap_q > 16'h0008 |-> gap_q >= 16'h012C)
      else $error("wait after wake too short");
   chk_sck_half: assert property (
      $rose(SPI_SCK_O) |-> s_sck_high)
      else $error("flash clock high time wrong");
   chk_sck_idle: assert property (
      SPI_CS_N_O && $past(SPI_CS_N_O) |-> !SPI_SCK_O)
      else $error("flash clock runs while deselected");
   chk_oe_cmd: assert property (
      SPI_DQ_OE_O != 4'h0 |-> SPI_DQ_OE_O == 4'h1 && !SPI_CS_N_O)
      else $error("bad output enable");
   chk_wr_pulse: assert property (
      CFG_WR_O |=> !CFG_WR_O)
      else $error("write strobe longer than a cycle");
   chk_wr_addr: assert property (
      CFG_WR_O |-> CFG_ADDR_O == next_q && CFG_ADDR_O < CFG_BYTES)
      else $error("write address out of sequence");
   chk_done_last: assert property (
      CFG_WR_O && CFG_ADDR_O == CFG_BYTES - 1 |-> ##[1:8] DONE_O && !BUSY_O)
      else $error("done missing after last write");
endmodule
bind cfl_loader cfl_loader_asserts #(.CFG_BYTES(CFG_BYTES)) cfl_loader_asserts_i (.*);
`default_nettype wire

// ===== tb/cfl_flash_model.sv
// Serial flash model answering wake-up and fast read
`timescale 1ns/1ps
`default_nettype none
module cfl_flash_model (
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic [1:0] width_i,
   output logic [3:0] dq_o,
   output logic [7:0] wake_o,
   output logic [39:0] cmd_o,
   output int gap_o
);
   int nb = 0;
   int bp = 0;
   int w;
   realtime t_up = 0;
   logic [7:0] by;
   initial dq_o = 4'h5;
   // New frame: measure the idle time since the wake-up frame ended
   always @(negedge cs_n_i)
   begin
      nb = 0;
      bp = 0;
      gap_o = int'($realtime - t_up);
   end
   always @(posedge cs_n_i)
   begin
      if (nb == 8)
      begin
         wake_o = cmd_o[7:0];
         t_up = $realtime;
      end
      dq_o = ~dq_o;
   end
   always @(posedge sck_i)
      if (!cs_n_i)
      begin
         if (nb < 40)
            cmd_o = {cmd_o[38:0], si_i};
         nb = nb + 1;
      end
   always @(negedge sck_i)
      if (!cs_n_i && nb >= 40)
      begin
         w = width_i == 2'h0 ? 1 : width_i == 2'h1 ? 2 : 4;
         by = 8'h3c ^ 8'((bp / 8) * 29);
         dq_o = 4'((by >> (8 - w - bp % 8)) & ((1 << w) - 1));
         bp = bp + w;
      end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking testbench of the configuration loader
`timescale 1ns/1ps
`default_nettype none
`include "cfl_loader_regs.vh"
module tb;
   logic clk = 0, nrst = 0, crst = 0, mask_en = 0, psck = 0, pcs = 1;
   logic tck = 0, tdi = 0, tsel = 0, sck, csn, wr, busy, done;
   logic [1:0] mode = 0, width = 0;
   logic [7:0] pdq = 0, mdata = 0, cdata, wake;
   logic [3:0] dqo, oe, fdq;
   logic [15:0] maddr, caddr;
   logic [39:0] cmd;
   logic [31:0] lfsr = 32'hbea4_3fc5;
   logic [23:0] exq[$];
   int gap, i, miscompares = 0, check_count = 0, cyc = 0;
   localparam logic [15:0] NB = 16'h0004;
   wire [3:0] dq = (oe & dqo) | (~oe & fdq);
   cfl_loader #(.CFG_BYTES(NB)) cfl_loader_i (
      .CLOCK_I(clk), .NRST_I(nrst), .CONFIG_RESET_N_I(crst), .MODE_I(mode),
      .WIDTH_I(width), .MASK_MEM_EN_I(mask_en), .SPI_SCK_O(sck), .SPI_CS_N_O(csn),
      .SPI_DQ_O(dqo), .SPI_DQ_OE_O(oe), .SPI_DQ_I(dq), .PSV_SCK_I(psck),
      .PSV_CS_N_I(pcs), .PSV_DQ_I(pdq), .JTAG_TCK_I(tck), .JTAG_TDI_I(tdi),
      .JTAG_CFG_SEL_I(tsel), .MASK_ADDR_O(maddr), .MASK_DATA_I(mdata), .CFG_WR_O(wr),
      .CFG_ADDR_O(caddr), .CFG_DATA_O(cdata), .BUSY_O(busy), .DONE_O(done));
   cfl_flash_model cfl_flash_model_i (.sck_i(sck), .cs_n_i(csn), .si_i(dq[0]),
      .width_i(width), .dq_o(fdq), .wake_o(wake), .cmd_o(cmd), .gap_o(gap));
   always #50 clk = ~clk;
   function automatic logic [31:0] lf(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] fb(input int n, input logic [7:0] s);
      return 8'h3c ^ 8'(n * 29) ^ s;
   endfunction
   task automatic cmp(input logic [39:0] g, input logic [39:0] e);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic stop_test();
      if (miscompares == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic clks(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Mask memory answers the cycle after the address
   always @(posedge clk)
      mdata <= fb(maddr, 8'h69);
   // Each write is checked against the oldest noted one
   always @(negedge clk)
      if (wr === 1'h1)
         cmp({caddr, cdata}, exq.size() ? exq.pop_front() : 24'hff_ffff);
   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         stop_test();
      end
   end
   task automatic start(input logic [1:0] m, input logic [1:0] w, input logic k);
      mode <= m;
      width <= w;
      mask_en <= k;
      clks(4);
      crst <= 1;
   endtask
   task automatic drop();
      crst <= 0;
      clks(6);
      cmp({done, busy, csn, sck, oe}, 8'h20);
   endtask
   task automatic wait_done();
      for (int n = 0; n < 3000 && done !== 1'h1; n++)
         clks(1);
      cmp({done, busy, 7'(exq.size())}, 9'h100);
      drop();
   endtask
   task automatic load(input logic [1:0] m, input logic [1:0] w, input logic k);
      for (int n = 0; n < NB; n++)
         exq.push_back({16'(n), fb(n, k ? 8'h69 : 8'h00)});
      start(m, w, k);
      wait_done();
   endtask
   task automatic send(input logic [1:0] m, input logic [1:0] w);
      logic j;
      int wi;
      j = m == `CFL_MODE_JTAG;
      wi = j ? 1 : 1 << w;
      start(m, w, 0);
      clks(4);
      pcs <= j;
      tsel <= j;
      for (int n = 0; n < NB; n++)
      begin
         lfsr = lf(lfsr);
         exq.push_back({16'(n), lfsr[7:0]});
         for (int k = 8 - wi; k >= 0; k -= wi)
         begin
            tdi <= lfsr[k];
            pdq <= 8'((lfsr[7:0] >> k) & ((1 << wi) - 1)) | (lfsr[15:8] << wi);
            clks(4);
            psck <= !j;
            tck <= j;
            clks(4);
            psck <= 0;
            tck <= 0;
         end
      end
      pcs <= 1;
      tsel <= 0;
      pdq <= ~pdq;
      wait_done();
   endtask
   initial
   begin
      clks(3);
      cmp({csn, busy, done, wr, sck, oe}, 9'h100);
      nrst <= 1;
      clks(3);
      for (i = 0; i < 4; i++)
      begin
         load(`CFL_MODE_ACTIVE, 2'(i), 0);
         cmp(wake, `CFL_OP_WAKE);
         cmp(cmd, {`CFL_OP_FAST_READ, `CFL_READ_START_ADDR, `CFL_DUMMY_BYTE});
         cmp(gap >= 30000, 1'h1);
      end
      for (i = 0; i < 4; i++)
         send(`CFL_MODE_PASSIVE, 2'(i));
      send(`CFL_MODE_JTAG, 2'h0);
      load(`CFL_MODE_PASSIVE, 2'h0, 1);
      start(`CFL_MODE_ACTIVE, 2'h0, 0);
      clks(100);
      drop();
      stop_test();
   end
endmodule
`default_nettype wire
